//--- verilog/ldqm_top.v
/*
  Linked data queue manager: APB register file, shared structure memory
  window and the engine that runs host commands and sequencer procedures.
  Assumes an APB master on pclk and entry links that point inside memory.
*/
`timescale 1ns/100ps
`include "ldqm_defines.vh"
module ldqm_top #(
  parameter MEM_AW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_reg,
  output reg pready_reg,
  output reg pslverr_reg
);
  localparam S_IDLE = 4'd0;
  localparam S_QRD = 4'd1;
  localparam S_QCAP = 4'd2;
  localparam S_ERD = 4'd3;
  localparam S_EC0 = 4'd4;
  localparam S_EC1 = 4'd5;
  localparam S_EC2 = 4'd6;
  localparam S_EXEC = 4'd7;
  localparam S_WR = 4'd8;

  reg [3:0] state_reg;
  reg [15:0] cmd_reg;
  reg [31:0] qptr_reg;
  reg [15:0] size_reg;
  reg [31:0] head_reg;
  reg [31:0] cur_reg;
  reg [31:0] nxt_reg;
  reg [31:0] w1_reg;
  reg [31:0] w2_reg;
  reg [31:0] qh_val_reg;
  reg [31:0] qt_val_reg;
  reg [7:0] st_val_reg;
  reg [31:0] w2_val_reg;
  reg [4:0] wmask_reg;
  reg [1:0] after_reg;
  reg phase_reg;
  reg [7:0] result_reg;
  reg [31:0] res_ptr_reg;
  reg [31:0] comp_ptr_reg;
  reg claimed_reg;
  reg [15:0] claim_size_reg;
  reg apb_ph_reg;

  reg mem_en;
  reg mem_we;
  reg [MEM_AW-1:0] mem_addr;
  reg [31:0] mem_wdata;
  wire [31:0] mem_rdata;

  function [MEM_AW-1:0] widx;
    input [31:0] p;
    input [1:0] off;
    begin
      widx = p[MEM_AW+1:2] + {{(MEM_AW-2){1'b0}}, off};
    end
  endfunction

  wire idle = (state_reg == S_IDLE);
  wire apb_acc = psel & penable & ~pready_reg;
  wire is_mem = (paddr >= `LDQM_MEM_BASE) &&
                ({1'b0, paddr} < ({1'b0, `LDQM_MEM_BASE} + (13'd4 << MEM_AW)));
  wire is_wreg = (paddr == `LDQM_CMD_OFS) | (paddr == `LDQM_QPTR_OFS) | (paddr == `LDQM_SIZE_OFS);
  wire is_rreg = (paddr == `LDQM_STAT_OFS) | (paddr == `LDQM_RES_OFS) | (paddr == `LDQM_COMP_OFS);
  // Writes while busy are refused so a running command sees stable arguments
  wire reg_err = ~(is_wreg | is_rreg) | (pwrite & is_rreg) | (pwrite & ~idle);
  wire start_go = apb_acc & ~is_mem & pwrite & ~reg_err & (paddr == `LDQM_CMD_OFS);
  wire apb_mem_go = apb_acc & is_mem & ~apb_ph_reg & idle;

  wire q_bad = (qptr_reg[1:0] != 2'b00) | (qptr_reg[31:MEM_AW+2] != 0) | (qptr_reg == 32'h0000_0000);

  wire [7:0] ent_st = w1_reg[7:0];
  wire is_multi = (w1_reg[15:8] == `LDQM_TYPE_MULTI);
  wire [17:0] ent_len = {2'b00, w1_reg[31:16]};
  wire [15:0] ent_fill = w2_reg[15:0];
  wire [15:0] ent_cnt = w2_reg[31:16];
  wire [17:0] need = {2'b00, ent_fill} + {2'b00, size_reg} + 18'd2;
  wire [17:0] size2 = {2'b00, size_reg} + 18'd2;
  wire len_short = ent_len < {2'b00, size_reg};
  wire empty = (cur_reg == 32'h0000_0000);
  wire hbusy = (ent_st == `LDQM_ST_BUSY);
  wire [4:0] wsel = wmask_reg & (~wmask_reg + 5'd1);

  reg [31:0] reg_rdata;
  always @* begin
    case (paddr)
      `LDQM_CMD_OFS: reg_rdata = {16'h0000, cmd_reg};
      `LDQM_QPTR_OFS: reg_rdata = qptr_reg;
      `LDQM_SIZE_OFS: reg_rdata = {16'h0000, size_reg};
      `LDQM_STAT_OFS: reg_rdata = {23'h000000, ~idle, result_reg};
      `LDQM_RES_OFS: reg_rdata = res_ptr_reg;
      `LDQM_COMP_OFS: reg_rdata = comp_ptr_reg;
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  // Memory port: engine owns it while running, APB only when idle
  always @* begin
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_addr = {MEM_AW{1'b0}};
    mem_wdata = 32'h0000_0000;
    case (state_reg)
      S_IDLE: begin
        mem_en = apb_mem_go;
        mem_we = pwrite;
        mem_addr = paddr[MEM_AW+1:2];
        mem_wdata = pwdata;
      end
      S_QRD: begin
        mem_en = 1'b1;
        mem_addr = widx(qptr_reg, `LDQM_Q_HEAD);
      end
      S_ERD: begin
        mem_en = 1'b1;
        mem_addr = widx(cur_reg, `LDQM_E_NEXT);
      end
      S_EC0: begin
        mem_en = 1'b1;
        mem_addr = widx(cur_reg, `LDQM_E_CTRL);
      end
      S_EC1: begin
        mem_en = 1'b1;
        mem_addr = widx(cur_reg, `LDQM_E_FILL);
      end
      S_WR: begin
        mem_en = (wmask_reg != 5'd0);
        mem_we = (wmask_reg != 5'd0);
        if (wsel[`LDQM_WM_QH]) begin
          mem_addr = widx(qptr_reg, `LDQM_Q_HEAD);
          mem_wdata = qh_val_reg;
        end else if (wsel[`LDQM_WM_QT]) begin
          mem_addr = widx(qptr_reg, `LDQM_Q_TAIL);
          mem_wdata = qt_val_reg;
        end else if (wsel[`LDQM_WM_E0]) begin
          mem_addr = widx(cur_reg, `LDQM_E_NEXT);
        end else if (wsel[`LDQM_WM_E1]) begin
          mem_addr = widx(cur_reg, `LDQM_E_CTRL);
          mem_wdata = {w1_reg[31:8], st_val_reg};
        end else begin
          mem_addr = widx(cur_reg, `LDQM_E_FILL);
          mem_wdata = w2_val_reg;
        end
      end
      default: begin
        mem_en = 1'b0;
      end
    endcase
  end

  ldqm_mem #(.AW(MEM_AW), .DW(32)) u_mem (
    .pclk(pclk),
    .en(mem_en),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_reg(mem_rdata)
  );

  // APB slave: registers answer in the second access cycle, memory in the third or later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      apb_ph_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      qptr_reg <= 32'h0000_0000;
      size_reg <= 16'h0000;
    end else begin
      pready_reg <= 1'b0;
      if (apb_acc) begin
        if (is_mem) begin
          if (!apb_ph_reg) begin
            if (idle) begin
              apb_ph_reg <= 1'b1;
            end
          end else begin
            apb_ph_reg <= 1'b0;
            pready_reg <= 1'b1;
            pslverr_reg <= 1'b0;
            prdata_reg <= pwrite ? 32'h0000_0000 : mem_rdata;
          end
        end else begin
          pready_reg <= 1'b1;
          pslverr_reg <= reg_err;
          prdata_reg <= (pwrite | reg_err) ? 32'h0000_0000 : reg_rdata;
          if (pwrite && !reg_err) begin
            case (paddr)
              `LDQM_CMD_OFS: cmd_reg <= pwdata[15:0];
              `LDQM_QPTR_OFS: qptr_reg <= pwdata;
              `LDQM_SIZE_OFS: size_reg <= pwdata[15:0];
              default: cmd_reg <= cmd_reg;
            endcase
          end
        end
      end
    end
  end

  // Engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      head_reg <= 32'h0000_0000;
      cur_reg <= 32'h0000_0000;
      nxt_reg <= 32'h0000_0000;
      w1_reg <= 32'h0000_0000;
      w2_reg <= 32'h0000_0000;
      qh_val_reg <= 32'h0000_0000;
      qt_val_reg <= 32'h0000_0000;
      st_val_reg <= `LDQM_ST_PENDING;
      w2_val_reg <= 32'h0000_0000;
      wmask_reg <= 5'd0;
      after_reg <= 2'd0;
      phase_reg <= 1'b0;
      result_reg <= `LDQM_RC_IDLE;
      res_ptr_reg <= 32'h0000_0000;
      comp_ptr_reg <= 32'h0000_0000;
      claimed_reg <= 1'b0;
      claim_size_reg <= 16'h0000;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (start_go) begin
            comp_ptr_reg <= 32'h0000_0000;
            res_ptr_reg <= 32'h0000_0000;
            phase_reg <= 1'b0;
            after_reg <= 2'd0;
            wmask_reg <= 5'd0;
            if (q_bad) begin
              result_reg <= `LDQM_RC_PARAM;
            end else begin
              state_reg <= S_QRD;
            end
          end
        end
        S_QRD: state_reg <= S_QCAP;
        S_QCAP: begin
          head_reg <= mem_rdata;
          cur_reg <= mem_rdata;
          w1_reg <= 32'h0000_0000;
          state_reg <= (mem_rdata == 32'h0000_0000) ? S_EXEC : S_ERD;
        end
        S_ERD: state_reg <= S_EC0;
        S_EC0: begin
          nxt_reg <= mem_rdata;
          state_reg <= S_EC1;
        end
        S_EC1: begin
          w1_reg <= mem_rdata;
          state_reg <= S_EC2;
        end
        S_EC2: begin
          w2_reg <= mem_rdata;
          state_reg <= S_EXEC;
        end
        S_EXEC: begin
          state_reg <= S_WR;
          case (cmd_reg)
            `LDQM_CMD_FLUSH: begin
              if (empty) begin
                result_reg <= `LDQM_RC_DONE;
                state_reg <= S_IDLE;
              end else if (hbusy) begin
                result_reg <= `LDQM_RC_QBUSY;
                state_reg <= S_IDLE;
              end else begin
                res_ptr_reg <= head_reg;
                qh_val_reg <= 32'h0000_0000;
                qt_val_reg <= 32'h0000_0000;
                wmask_reg <= 5'b00011;
              end
            end
            `LDQM_CMD_CLEAR: begin
              if (!phase_reg && (empty || hbusy)) begin
                result_reg <= `LDQM_RC_QUEUE;
                state_reg <= S_IDLE;
              end else begin
                st_val_reg <= `LDQM_ST_PENDING;
                w2_val_reg <= 32'h0000_0000;
                wmask_reg <= is_multi ? 5'b11000 : 5'b01000;
                after_reg <= 2'd1;
              end
            end
            `LDQM_CMD_DROP: begin
              if (empty) begin
                result_reg <= `LDQM_RC_DONE;
                state_reg <= S_IDLE;
              end else if (ent_st == `LDQM_ST_PENDING) begin
                res_ptr_reg <= head_reg;
                qh_val_reg <= 32'h0000_0000;
                wmask_reg <= 5'b00001;
              end else begin
                res_ptr_reg <= nxt_reg;
                qt_val_reg <= head_reg;
                wmask_reg <= 5'b00110;
              end
            end
            `LDQM_PROC_CLAIM_TX: begin
              if (empty || hbusy) begin
                result_reg <= `LDQM_RC_ERROR;
                state_reg <= S_IDLE;
              end else begin
                st_val_reg <= `LDQM_ST_BUSY;
                res_ptr_reg <= head_reg;
                wmask_reg <= 5'b01000;
              end
            end
            `LDQM_PROC_RELEASE: begin
              claimed_reg <= 1'b0;
              if (empty) begin
                result_reg <= `LDQM_RC_ERROR;
                state_reg <= S_IDLE;
              end else begin
                st_val_reg <= `LDQM_ST_ACTIVE;
                res_ptr_reg <= head_reg;
                wmask_reg <= 5'b01000;
              end
            end
            `LDQM_PROC_RETIRE: begin
              if (empty) begin
                result_reg <= `LDQM_RC_ERROR;
                state_reg <= S_IDLE;
              end else begin
                qh_val_reg <= nxt_reg;
                st_val_reg <= `LDQM_ST_FINISHED;
                res_ptr_reg <= nxt_reg;
                wmask_reg <= 5'b01001;
              end
            end
            `LDQM_PROC_CLAIM_RX: begin
              if (phase_reg) begin
                if (ent_len < size2) begin
                  result_reg <= `LDQM_RC_NOSPACE;
                  state_reg <= S_IDLE;
                end else begin
                  st_val_reg <= `LDQM_ST_BUSY;
                  res_ptr_reg <= cur_reg;
                  wmask_reg <= 5'b01000;
                  claimed_reg <= 1'b1;
                  claim_size_reg <= size_reg;
                end
              end else if (empty) begin
                result_reg <= `LDQM_RC_NOSPACE;
                state_reg <= S_IDLE;
              end else if (hbusy) begin
                result_reg <= `LDQM_RC_ERROR;
                state_reg <= S_IDLE;
              end else if (!is_multi && len_short) begin
                result_reg <= `LDQM_RC_NOSPACE;
                state_reg <= S_IDLE;
              end else if (is_multi && (need > ent_len)) begin
                qh_val_reg <= nxt_reg;
                st_val_reg <= `LDQM_ST_FINISHED;
                comp_ptr_reg <= cur_reg;
                wmask_reg <= 5'b01001;
                after_reg <= 2'd2;
              end else begin
                st_val_reg <= `LDQM_ST_BUSY;
                res_ptr_reg <= cur_reg;
                wmask_reg <= 5'b01000;
                claimed_reg <= 1'b1;
                claim_size_reg <= size_reg;
              end
            end
            `LDQM_PROC_COMMIT: begin
              claimed_reg <= 1'b0;
              res_ptr_reg <= cur_reg;
              if (empty || !claimed_reg || (size_reg != claim_size_reg)) begin
                result_reg <= `LDQM_RC_ERROR;
                state_reg <= S_IDLE;
              end else if (is_multi ? (need > ent_len) : len_short) begin
                result_reg <= `LDQM_RC_ERROR;
                state_reg <= S_IDLE;
              end else if (!is_multi) begin
                qh_val_reg <= nxt_reg;
                st_val_reg <= `LDQM_ST_FINISHED;
                wmask_reg <= 5'b01001;
              end else begin
                w2_val_reg <= {ent_cnt + 16'd1, ent_fill + size_reg};
                if (need == ent_len) begin
                  qh_val_reg <= nxt_reg;
                  st_val_reg <= `LDQM_ST_FINISHED;
                  comp_ptr_reg <= cur_reg;
                  wmask_reg <= 5'b11001;
                end else begin
                  st_val_reg <= `LDQM_ST_ACTIVE;
                  wmask_reg <= 5'b11000;
                end
              end
            end
            default: begin
              result_reg <= `LDQM_RC_UNKNOWN;
              state_reg <= S_IDLE;
            end
          endcase
        end
        S_WR: begin
          if (wmask_reg != 5'd0) begin
            wmask_reg <= wmask_reg & ~wsel;
          end else if (after_reg == 2'd1) begin
            // Stop on null link or wrap back to head, a ring never loops forever
            if ((nxt_reg == 32'h0000_0000) || (nxt_reg == head_reg)) begin
              result_reg <= `LDQM_RC_DONE;
              state_reg <= S_IDLE;
            end else begin
              cur_reg <= nxt_reg;
              phase_reg <= 1'b1;
              state_reg <= S_ERD;
            end
          end else if (after_reg == 2'd2) begin
            after_reg <= 2'd0;
            if (nxt_reg == 32'h0000_0000) begin
              result_reg <= `LDQM_RC_NOSPACE;
              state_reg <= S_IDLE;
            end else begin
              cur_reg <= nxt_reg;
              phase_reg <= 1'b1;
              state_reg <= S_ERD;
            end
          end else begin
            result_reg <= `LDQM_RC_DONE;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

//--- inc/ldqm_defines.vh
/*
  Constants for the linked data queue manager: register offsets, memory
  layout of queues and entries, state and result encodings, command numbers.
  Assumes it is included once per design file by its bare name.
*/
`ifndef LDQM_DEFINES_VH
`define LDQM_DEFINES_VH

`define LDQM_CMD_OFS 12'h000
`define LDQM_QPTR_OFS 12'h004
`define LDQM_SIZE_OFS 12'h008
`define LDQM_STAT_OFS 12'h00c
`define LDQM_RES_OFS 12'h010
`define LDQM_COMP_OFS 12'h014
`define LDQM_MEM_BASE 12'h400

`define LDQM_Q_HEAD 2'h0
`define LDQM_Q_TAIL 2'h1
`define LDQM_E_NEXT 2'h0
`define LDQM_E_CTRL 2'h1
`define LDQM_E_FILL 2'h2

`define LDQM_ST_PENDING 8'h00
`define LDQM_ST_ACTIVE 8'h01
`define LDQM_ST_BUSY 8'h02
`define LDQM_ST_FINISHED 8'h03
`define LDQM_TYPE_MULTI 8'h01

`define LDQM_RC_IDLE 8'h00
`define LDQM_RC_DONE 8'h01
`define LDQM_RC_PARAM 8'h81
`define LDQM_RC_QUEUE 8'h82
`define LDQM_RC_QBUSY 8'h83
`define LDQM_RC_NOSPACE 8'h84
`define LDQM_RC_ERROR 8'h85
`define LDQM_RC_UNKNOWN 8'h86

`define LDQM_CMD_FLUSH 16'h0007
`define LDQM_CMD_CLEAR 16'h0008
`define LDQM_CMD_DROP 16'h0009
`define LDQM_PROC_CLAIM_TX 16'h0101
`define LDQM_PROC_RELEASE 16'h0102
`define LDQM_PROC_RETIRE 16'h0103
`define LDQM_PROC_CLAIM_RX 16'h0104
`define LDQM_PROC_COMMIT 16'h0105

`define LDQM_WM_QH 0
`define LDQM_WM_QT 1
`define LDQM_WM_E0 2
`define LDQM_WM_E1 3
`define LDQM_WM_E2 4

`endif

//--- verilog/ldqm_mem.v
/*
  Single-port word memory holding queue and entry structures.
  Assumes one requester at a time; read data appear one edge after en.
*/
`timescale 1ns/100ps
module ldqm_mem #(
  parameter AW = 8,
  parameter DW = 32
) (
  input wire pclk,
  input wire en,
  input wire we,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata_reg
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array, contents are owned by software
  always @(posedge pclk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_reg <= mem[addr];
    end
  end
endmodule

//--- verilog/ldqm_unused_placeholder_none.v
/*
  Intentionally empty; no further modules.
*/
`timescale 1ns/100ps

//--- bench/ldqm_chk.sv
/*
  Port checker for the queue manager: APB answer timing, error responses
  and status encodings. Assumes it is bound to ldqm_top with its MEM_AW.
*/
`timescale 1ns/100ps
module ldqm_chk #(
  parameter MEM_AW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_reg,
  input wire pready_reg,
  input wire pslverr_reg
);
  localparam [31:0] MBYTES = 32'h4 << MEM_AW;
  localparam [31:0] WEND = 32'h400 + MBYTES;
  reg pen_reg;
  reg qbad_reg;
  reg cbad_reg;
  wire first = psel && penable && !pen_reg;
  wire wdone = pready_reg && !pslverr_reg && pwrite;
  wire stat_rd = pready_reg && !pwrite && paddr == 12'h00c;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Remembers a bad pointer so the next status read can be judged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_reg <= 1'b0;
      qbad_reg <= 1'b0;
      cbad_reg <= 1'b0;
    end else begin
      pen_reg <= penable;
      if (wdone && paddr == 12'h004) begin
        qbad_reg <= pwdata[1:0] != 2'b00 || pwdata == 32'h0 || pwdata >= MBYTES;
      end
      if (wdone && paddr == 12'h000) begin
        cbad_reg <= qbad_reg && pwdata[15:0] >= 16'h0007 && pwdata[15:0] <= 16'h0009;
      end
    end
  end
  ready_pulse_a: assert property (pready_reg |=> !pready_reg)
    else $error("ready held too long");
  ready_access_a: assert property (pready_reg |-> psel && penable)
    else $error("ready outside access");
  reg_answer_a: assert property (first && paddr <= 12'h014 |=> pready_reg)
    else $error("register answer late");
  mem_answer_a: assert property (first && paddr >= 12'h400 && {20'h0, paddr} < WEND |=> !pready_reg ##[1:400] pready_reg)
    else $error("memory answer timing");
  unmapped_err_a: assert property (pready_reg && (paddr >= 12'h018 && paddr < 12'h400 || {20'h0, paddr} >= WEND)
    |-> pslverr_reg)
    else $error("unmapped without error");
  ro_write_a: assert property (pready_reg && pwrite && paddr >= 12'h00c && paddr <= 12'h014 |-> pslverr_reg)
    else $error("read-only write accepted");
  zero_data_a: assert property (pready_reg && (pwrite || pslverr_reg) |-> prdata_reg == 32'h0)
    else $error("data not zero");
  status_code_a: assert property (stat_rd |-> prdata_reg[31:9] == 23'h0 &&
    (prdata_reg[7:0] <= 8'h01 || prdata_reg[7:0] >= 8'h81 && prdata_reg[7:0] <= 8'h86))
    else $error("bad status encoding");
  bad_pointer_a: assert property (stat_rd && cbad_reg |-> prdata_reg[8:0] == 9'h081)
    else $error("bad pointer not refused");
endmodule
bind ldqm_top ldqm_chk #(.MEM_AW(MEM_AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
  .pslverr_reg(pslverr_reg));

//--- bench/ldqm_host.sv
/*
  Host model: APB master issuing one transfer at a time.
  Assumes callers enter right after a rising edge of pclk.
*/
`timescale 1ns/100ps
module ldqm_host (
  input wire pclk,
  output reg psel = 1'b0,
  output reg penable = 1'b0,
  output reg pwrite = 1'b0,
  output reg [11:0] paddr = 12'h0,
  output reg [31:0] pwdata = 32'h0,
  input wire [31:0] prdata_reg,
  input wire pready_reg,
  input wire pslverr_reg
);
  task xfer(input reg w, input reg [11:0] a, input reg [31:0] d, output reg [31:0] q, output reg e);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready_reg !== 1'b1 && n < 1000) begin
        @(posedge pclk);
        n = n + 1;
      end
      // A slave that never answers counts as a mismatch of the bench
      if (pready_reg !== 1'b1) begin
        tb_ldqm_top.n_fail = tb_ldqm_top.n_fail + 1;
        $display("[ERR] %0t no ready from slave", $time);
      end
      q = prdata_reg;
      e = pslverr_reg;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data must not look valid once released
      pwdata <= ~d;
      @(posedge pclk);
    end
  endtask
endmodule

//--- bench/tb_ldqm_top.sv
/*
  Bench for the queue manager: builds queues in the memory window, runs
  commands and procedures, compares results. Assumes host model and checker.
*/
`timescale 1ns/100ps
`include "ldqm_defines.vh"
module tb_ldqm_top;
  localparam [7:0] OK = `LDQM_RC_DONE, ER = `LDQM_RC_ERROR, NS = `LDQM_RC_NOSPACE, MU = `LDQM_TYPE_MULTI;
  localparam [7:0] PE = `LDQM_ST_PENDING, AC = `LDQM_ST_ACTIVE, BU = `LDQM_ST_BUSY, FI = `LDQM_ST_FINISHED;
  localparam [15:0] FL = `LDQM_CMD_FLUSH, CL = `LDQM_CMD_CLEAR, DR = `LDQM_CMD_DROP, CT = `LDQM_PROC_CLAIM_TX;
  localparam [15:0] RL = `LDQM_PROC_RELEASE, RT = `LDQM_PROC_RETIRE, CR = `LDQM_PROC_CLAIM_RX, CM = `LDQM_PROC_COMMIT;
  localparam [11:0] RES = `LDQM_RES_OFS, CMP = `LDQM_COMP_OFS, STA = `LDQM_STAT_OFS;
  localparam [31:0] Q = 32'h10, A = 32'h40, B = 32'h60;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  wire psel, penable, pwrite, pready_reg, pslverr_reg;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata_reg;
  integer n_fail = 0, samples_checked = 0, seed = 2848, i;
  reg [31:0] rv, rn;
  reg [15:0] s1;
  reg ev;
  always #5 pclk = ~pclk;
  ldqm_top #(.MEM_AW(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg));
  ldqm_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    u_host.xfer(1'b1, a, d, rv, ev);
  endtask
  task rs(input [11:0] a, input [31:0] e);
    begin
      u_host.xfer(1'b0, a, 32'h0, rv, ev);
      chk(rv, e);
    end
  endtask
  task mc(input [31:0] p, input [31:0] e);
    rs(12'h400 + p[11:0], e);
  endtask
  function [31:0] ctl(input [15:0] len, input [7:0] ty, input [7:0] st);
    ctl = {len, ty, st};
  endfunction
  task ent(input [31:0] p, input [31:0] nx, input [31:0] c, input [31:0] f);
    begin
      wr(12'h400 + p[11:0], nx);
      wr(12'h404 + p[11:0], c);
      wr(12'h408 + p[11:0], f);
    end
  endtask
  task qs(input [31:0] h, input [31:0] t);
    begin
      wr(12'h400 + Q[11:0], h);
      wr(12'h404 + Q[11:0], t);
    end
  endtask
  // Polls with a bound; a stuck engine shows as busy or a wrong code
  task wt(input [7:0] e);
    integer k;
    begin
      k = 0;
      u_host.xfer(1'b0, STA, 32'h0, rv, ev);
      while (rv[8] !== 1'b0 && k < 200) begin
        u_host.xfer(1'b0, STA, 32'h0, rv, ev);
        k = k + 1;
      end
      chk({23'h0, rv[8:0]}, {24'h0, e});
    end
  endtask
  task run(input [15:0] c, input [31:0] q, input [15:0] sz, input [7:0] e);
    begin
      wr(`LDQM_QPTR_OFS, q);
      wr(`LDQM_SIZE_OFS, {16'h0, sz});
      wr(`LDQM_CMD_OFS, {16'h0, c});
      wt(e);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  initial begin
    #300000;
    n_fail = n_fail + 1;
    final_report;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rs(STA, 32'h0);
    rs(12'h018, 32'h0);
    chk({31'h0, ev}, 32'h1);
    wr(RES, 32'h5);
    chk({31'h0, ev}, 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      rn = $random(seed);
      run(FL + i[15:0], {22'h0, rn[9:2], 2'b01}, 16'h0, `LDQM_RC_PARAM);
      run(FL + i[15:0], 32'h400, 16'h0, `LDQM_RC_PARAM);
    end
    qs(0, 0);
    run(16'h00ff, Q, 16'h0, `LDQM_RC_UNKNOWN);
    run(FL, Q, 16'h0, OK);
    rs(RES, 0);
    run(DR, Q, 16'h0, OK);
    rs(RES, 0);
    run(CL, Q, 16'h0, `LDQM_RC_QUEUE);
    ent(A, B, ctl(16'h10, 8'h0, AC), 0);
    ent(B, 0, ctl(16'h10, 8'h0, AC), 0);
    qs(A, B);
    run(FL, Q, 16'h0, OK);
    rs(RES, A);
    mc(Q, 0);
    mc(Q + 4, 0);
    qs(A, B);
    wr(12'h404 + A[11:0], ctl(16'h10, 8'h0, BU));
    run(FL, Q, 16'h0, `LDQM_RC_QBUSY);
    mc(Q, A);
    ent(A, B, ctl(16'h10, MU, AC), 32'h0002000a);
    ent(B, A, ctl(16'h10, 8'h0, FI), 32'h00030005);
    qs(A, B);
    // Argument write during the walk must be refused
    wr(`LDQM_QPTR_OFS, Q);
    wr(`LDQM_CMD_OFS, {16'h0, CL});
    wr(`LDQM_QPTR_OFS, 32'h4);
    chk({31'h0, ev}, 32'h1);
    wt(OK);
    mc(A + 4, ctl(16'h10, MU, PE));
    mc(A + 8, 0);
    mc(B + 4, ctl(16'h10, 8'h0, PE));
    mc(B + 8, 32'h00030005);
    wr(12'h404 + A[11:0], ctl(16'h10, MU, BU));
    run(CL, Q, 16'h0, `LDQM_RC_QUEUE);
    ent(A, B, ctl(16'h10, 8'h0, PE), 0);
    qs(A, B);
    run(DR, Q, 16'h0, OK);
    rs(RES, A);
    mc(Q, 0);
    wr(12'h404 + A[11:0], ctl(16'h10, 8'h0, AC));
    qs(A, B);
    run(DR, Q, 16'h0, OK);
    rs(RES, B);
    mc(A, 0);
    mc(Q + 4, A);
    qs(0, 0);
    for (i = 0; i < 3; i = i + 1)
      run(CT + i[15:0], Q, 16'h0, ER);
    ent(A, B, ctl(16'h10, 8'h0, AC), 0);
    ent(B, 0, ctl(16'h10, 8'h0, AC), 0);
    qs(A, B);
    run(CT, Q, 16'h0, OK);
    rs(RES, A);
    mc(A + 4, ctl(16'h10, 8'h0, BU));
    run(CT, Q, 16'h0, ER);
    run(RL, Q, 16'h0, OK);
    mc(A + 4, ctl(16'h10, 8'h0, AC));
    mc(Q, A);
    run(RT, Q, 16'h0, OK);
    rs(RES, B);
    mc(Q, B);
    mc(A + 4, ctl(16'h10, 8'h0, FI));
    qs(0, 0);
    run(CR, Q, 16'h4, NS);
    run(CM, Q, 16'h4, ER);
    ent(A, B, ctl(16'h14, 8'h0, BU), 0);
    ent(B, 0, ctl(16'h1e, MU, PE), 0);
    qs(A, B);
    run(CR, Q, 16'h4, ER);
    wr(12'h404 + A[11:0], ctl(16'h14, 8'h0, PE));
    run(CR, Q, 16'h15, NS);
    run(CM, Q, 16'h14, ER);
    run(CR, Q, 16'h14, OK);
    rs(RES, A);
    rs(CMP, 0);
    mc(A + 4, ctl(16'h14, 8'h0, BU));
    run(CM, Q, 16'h14, OK);
    mc(Q, B);
    mc(A + 4, ctl(16'h14, 8'h0, FI));
    rn = $random(seed);
    s1 = {13'h0, rn[2:0]} + 16'h2;
    run(CR, Q, s1, OK);
    rs(RES, B);
    run(CM, Q, s1, OK);
    mc(B + 4, ctl(16'h1e, MU, AC));
    mc(B + 8, {16'h1, s1});
    rs(CMP, 0);
    run(CR, Q, 16'h1c - s1, OK);
    run(CM, Q, 16'h1c - s1, OK);
    rs(CMP, B);
    mc(Q, 0);
    mc(B + 4, ctl(16'h1e, MU, FI));
    mc(B + 8, 32'h0002001c);
    for (i = 0; i < 2; i = i + 1) begin
      ent(A, B, ctl(16'h1e, MU, AC), 32'h00010014);
      ent(B, 0, ctl(i ? 16'h28 : 16'h8, 8'h0, PE), 0);
      qs(A, B);
      run(CR, Q, 16'ha, i ? OK : NS);
      mc(Q, B);
      mc(A + 4, ctl(16'h1e, MU, FI));
    end
    rs(CMP, A);
    rs(RES, B);
    mc(B + 4, ctl(16'h28, 8'h0, BU));
    final_report;
  end
endmodule
